// ==== bpr_defs.svh ====
/*
 * Constants of the pressure sensor register bank: addresses, field
 * positions, reset values and timing counts.
 * Assumes a 200 MHz core clock and a host that frames accesses with
 * the serial select pin.
 */
`ifndef BPR_DEFS_SVH
`define BPR_DEFS_SVH


// ----------------------------------------
// Register addresses
// ----------------------------------------
`define BPR_ADDR_PART_CODE 8'hd1
`define BPR_ADDR_SOFT_RESET 8'he0
`define BPR_ADDR_IIR 8'hf1
`define BPR_ADDR_HS_CODE 8'hf2
`define BPR_ADDR_STATUS 8'hf3
`define BPR_ADDR_MEAS_CTRL 8'hf4
`define BPR_ADDR_IO_SETUP 8'hf5
`define BPR_ADDR_BARO_HIGH 8'hf7
`define BPR_ADDR_BARO_MID 8'hf8
`define BPR_ADDR_BARO_LOW 8'hf9
`define BPR_ADDR_TEMP_HIGH 8'hfa
`define BPR_ADDR_TEMP_MID 8'hfb
`define BPR_ADDR_TEMP_LOW 8'hfc
`define BPR_SPI_ADDR_BIT 7

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BPR_SOFT_RESET_KEY 8'he6
`define BPR_RST_BYTE 8'h00
`define BPR_RST_HS_CODE 3'h1
`define BPR_STATUS_MEAS_BIT 3
`define BPR_STATUS_OTP_BIT 0
`define BPR_MODE_IDLE 2'h0
`define BPR_MODE_REPEAT 2'h3
`define BPR_OS_SKIP 3'h0
`define BPR_OS_22BIT 3'h1
`define BPR_OS_23BIT 3'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define BPR_CLK_PERIOD_PS 5000
`define BPR_OTP_TIME_NS 500
`define BPR_CONV_TIME_NS 2000
`define BPR_STBY_UNIT_TIME_NS 500
`define BPR_NS_TO_CYC(t) (((t) * 1000 + `BPR_CLK_PERIOD_PS - 1) / `BPR_CLK_PERIOD_PS)
`define BPR_OTP_CYC `BPR_NS_TO_CYC(`BPR_OTP_TIME_NS)
`define BPR_CONV_CYC `BPR_NS_TO_CYC(`BPR_CONV_TIME_NS)
`define BPR_STBY_UNIT_CYC `BPR_NS_TO_CYC(`BPR_STBY_UNIT_TIME_NS)

`endif

// ==== bpr_pkg.sv ====
/*
 * Types shared by the pressure sensor register bank.
 * Assumes nothing of its surroundings.
 */
package bpr_pkg;

    typedef enum logic [1:0] {bpr_ph_load, bpr_ph_idle, bpr_ph_conv, bpr_ph_wait} bpr_phase_e;

    typedef struct packed {
        logic [2:0] stby_sel;
        logic drive_type;
        logic three_wire;
    } bpr_io_s;

    typedef struct packed {
        logic [2:0] temp_os;
        logic [2:0] baro_os;
        logic [1:0] run_mode;
    } bpr_meas_s;

    typedef struct packed {
        bpr_io_s io;
        bpr_meas_s meas;
        logic [2:0] hs_code;
        logic [2:0] iir_sel;
    } bpr_cfg_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } bpr_access_s;

    typedef struct packed {
        logic stage1;
        logic stage2;
    } bpr_sync_s;

    typedef struct packed {
        logic [2:0] bit_cnt;
        logic addr_done;
        logic rd_mode;
        logic [6:0] shreg;
        logic [7:0] addr;
        bpr_access_s wr;
        logic wr_tgl;
        logic rd_tgl;
    } bpr_link_s;

endpackage

// ==== bpr_sync.sv ====
/*
 * Two-stage synchroniser for one level.
 * Assumes the input is held long enough to be seen by the clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bpr_sync
    import bpr_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);

    bpr_sync_s st_q;
    bpr_sync_s st_d;

    always_comb
    begin
        st_d.stage1 = async_in;
        st_d.stage2 = st_q.stage1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.stage2;

endmodule // bpr_sync

`default_nettype wire

// ==== bpr_link.sv ====
/*
 * Serial port logic on the host's serial clock: address byte, write
 * bytes and read bytes with auto-increment, toggle events toward the core.
 * Assumes the host samples on the rising edge and pauses after each byte.
 */
`timescale 1ns/10ps
`default_nettype none

`include "bpr_defs.svh"

module bpr_link
    import bpr_pkg::*;
(
    input wire logic arst_n,
    input wire logic sck,
    input wire logic csb_n,
    input wire logic sdi_i,
    input wire logic three_wire,
    input wire logic drive_type,
    input wire logic [7:0] rd_data,
    output logic sdi_o,
    output logic sdi_oe,
    output logic sdo_o,
    output logic sdo_oe,
    output logic [7:0] rd_addr,
    output logic rd_tgl,
    output bpr_access_s wr,
    output logic wr_tgl
);

    bpr_link_s st_q;
    bpr_link_s st_d;
    logic frame_new_q;
    logic [2:0] cnt;
    logic in_data;
    logic [7:0] byte_in;
    logic reading;
    logic data_bit;

    // Clock stops between frames, so the select pin itself marks a new frame
    always_ff @(posedge sck or posedge csb_n)
    begin
        if (csb_n)
        begin
            frame_new_q <= 1'b1;
        end
        else
        begin
            frame_new_q <= 1'b0;
        end
    end

    always_comb
    begin
        st_d = st_q;
        cnt = frame_new_q ? 3'h0 : st_q.bit_cnt;
        in_data = frame_new_q ? 1'b0 : st_q.addr_done;
        byte_in = {st_q.shreg, sdi_i};
        st_d.shreg = byte_in[6:0];
        st_d.bit_cnt = cnt + 3'h1;
        st_d.addr_done = in_data;
        if (cnt == 3'h7)
        begin
            if (!in_data)
            begin
                st_d.addr_done = 1'b1;
                st_d.rd_mode = byte_in[7];
                st_d.addr = {1'b1, byte_in[6:0]};
                st_d.rd_tgl = st_q.rd_tgl ^ byte_in[7];
            end
            else
            begin
                if (!st_q.rd_mode)
                begin
                    st_d.wr = '{addr: st_q.addr, data: byte_in};
                    st_d.wr_tgl = ~st_q.wr_tgl;
                end
                st_d.addr = {1'b1, st_q.addr[6:0] + 7'h01};
                st_d.rd_tgl = st_q.rd_tgl ^ st_q.rd_mode;
            end
        end
    end

    always_ff @(posedge sck or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Read data drive
    // ----------------------------------------
    assign reading = ~frame_new_q & ~csb_n & st_q.addr_done & st_q.rd_mode;
    assign data_bit = rd_data[~st_q.bit_cnt];
    assign sdo_o = data_bit;
    assign sdo_oe = reading & ~three_wire;
    // Open-drain form only pulls low, so a high bit leaves the pin released
    assign sdi_o = drive_type ? 1'b0 : data_bit;
    assign sdi_oe = reading & three_wire & (~drive_type | ~data_bit);
    assign rd_addr = st_q.addr;
    assign rd_tgl = st_q.rd_tgl;
    assign wr = st_q.wr;
    assign wr_tgl = st_q.wr_tgl;

endmodule // bpr_link

`default_nettype wire

// ==== bpr_top.sv ====
/*
 * Register bank of the barometric pressure sensor: configuration,
 * status, results, identity and soft reset, with the measurement
 * sequencer that feeds the results.
 * Assumes a conversion engine on the core clock that presents its
 * samples right-aligned, and a host on the serial pins with its own clock.
 */
`timescale 1ns/10ps
`default_nettype none

`include "bpr_defs.svh"

module bpr_top
    import bpr_pkg::*;
#(
    parameter logic [7:0] PART_CODE = 8'h3a, // Arbitrary value
    parameter int unsigned OTP_CYC = `BPR_OTP_CYC,
    parameter int unsigned CONV_CYC = `BPR_CONV_CYC,
    parameter int unsigned STBY_UNIT_CYC = `BPR_STBY_UNIT_CYC
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic csb_n,
    input wire logic sdi_i,
    output logic sdi_o,
    output logic sdi_oe,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic [23:0] temp_sample,
    input wire logic [23:0] baro_sample,
    output bpr_cfg_s cfg_o,
    output logic conv_busy,
    output logic otp_busy
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        bpr_phase_e phase;
        bpr_cfg_s cfg;
        logic [15:0] timer;
        logic [23:0] temp_res;
        logic [23:0] baro_res;
        logic [7:0] rd_data;
        logic wr_seen;
        logic rd_seen;
    } bpr_top_s;

    localparam bpr_cfg_s CFG_RST = '{
        io: '0,
        meas: '0,
        hs_code: `BPR_RST_HS_CODE,
        iir_sel: '0
    };

    localparam bpr_top_s TOP_RST = '{
        phase: bpr_ph_load,
        cfg: CFG_RST,
        timer: 16'(OTP_CYC),
        temp_res: '0,
        baro_res: '0,
        rd_data: `BPR_RST_BYTE,
        wr_seen: 1'b0,
        rd_seen: 1'b0
    };

    bpr_top_s st_q;
    bpr_top_s st_d;

    logic [7:0] link_rd_addr;
    logic link_rd_tgl;
    bpr_access_s link_wr;
    logic link_wr_tgl;
    logic [1:0] tgl_async;
    logic [1:0] tgl_sync;
    logic wr_event;
    logic rd_event;
    logic [7:0] status_byte;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Short conversions shift their low bits up to the top and fill the rest with zero
    function automatic logic [23:0] align_result(input logic [23:0] sample, input logic [2:0] os);
        logic [23:0] res;
        res = sample;
        if (os == `BPR_OS_22BIT)
        begin
            res = {sample[21:0], 2'b00};
        end
        else if (os == `BPR_OS_23BIT)
        begin
            res = {sample[22:0], 1'b0};
        end
        return res;
    endfunction

    function automatic logic [15:0] stby_count(input logic [2:0] sel);
        return 16'(STBY_UNIT_CYC) << sel;
    endfunction

    function automatic logic [7:0] reg_read(input bpr_top_s s, input logic [7:0] addr,
                                            input logic [7:0] stat);
        logic [7:0] val;
        val = 8'h00;
        if (addr == `BPR_ADDR_PART_CODE)
        begin
            val = PART_CODE;
        end
        else if (addr == `BPR_ADDR_IIR)
        begin
            val = {5'h00, s.cfg.iir_sel};
        end
        else if (addr == `BPR_ADDR_HS_CODE)
        begin
            val = {5'h00, s.cfg.hs_code};
        end
        else if (addr == `BPR_ADDR_STATUS)
        begin
            val = stat;
        end
        else if (addr == `BPR_ADDR_MEAS_CTRL)
        begin
            val = s.cfg.meas;
        end
        else if (addr == `BPR_ADDR_IO_SETUP)
        begin
            val = {s.cfg.io.stby_sel, 2'b00, s.cfg.io.drive_type, 1'b0, s.cfg.io.three_wire};
        end
        else if (addr == `BPR_ADDR_BARO_HIGH)
        begin
            val = s.baro_res[23:16];
        end
        else if (addr == `BPR_ADDR_BARO_MID)
        begin
            val = s.baro_res[15:8];
        end
        else if (addr == `BPR_ADDR_BARO_LOW)
        begin
            val = s.baro_res[7:0];
        end
        else if (addr == `BPR_ADDR_TEMP_HIGH)
        begin
            val = s.temp_res[23:16];
        end
        else if (addr == `BPR_ADDR_TEMP_MID)
        begin
            val = s.temp_res[15:8];
        end
        else if (addr == `BPR_ADDR_TEMP_LOW)
        begin
            val = s.temp_res[7:0];
        end
        return val;
    endfunction

    // ----------------------------------------
    // Serial link and crossing
    // ----------------------------------------
    bpr_link u_link (
        .arst_n(arst_n),
        .sck(sck),
        .csb_n(csb_n),
        .sdi_i(sdi_i),
        .three_wire(st_q.cfg.io.three_wire),
        .drive_type(st_q.cfg.io.drive_type),
        .rd_data(st_q.rd_data),
        .sdi_o(sdi_o),
        .sdi_oe(sdi_oe),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe),
        .rd_addr(link_rd_addr),
        .rd_tgl(link_rd_tgl),
        .wr(link_wr),
        .wr_tgl(link_wr_tgl)
    );

    assign tgl_async = {link_rd_tgl, link_wr_tgl};

    // Events cross as toggles; address and data stay put for a whole byte
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_tgl_sync
            bpr_sync u_sync (
                .clock(clock),
                .arst_n(arst_n),
                .async_in(tgl_async[i]),
                .sync_out(tgl_sync[i])
            );
        end
    endgenerate

    assign wr_event = tgl_sync[0] ^ st_q.wr_seen;
    assign rd_event = tgl_sync[1] ^ st_q.rd_seen;

    // ----------------------------------------
    // Status
    // ----------------------------------------
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[`BPR_STATUS_MEAS_BIT] = (st_q.phase == bpr_ph_conv);
        status_byte[`BPR_STATUS_OTP_BIT] = (st_q.phase == bpr_ph_load);
    end

    // ----------------------------------------
    // Sequencer and register writes
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.wr_seen = tgl_sync[0];
        st_d.rd_seen = tgl_sync[1];

        if (rd_event)
        begin
            st_d.rd_data = reg_read(st_q, link_rd_addr, status_byte);
        end

        case (st_q.phase)
            bpr_ph_load:
            begin
                // Calibration memory read after any reset
                if (st_q.timer <= 16'h0001)
                begin
                    st_d.phase = bpr_ph_idle;
                end
                else
                begin
                    st_d.timer = st_q.timer - 16'h0001;
                end
            end
            bpr_ph_idle:
            begin
                if (st_q.cfg.meas.run_mode != `BPR_MODE_IDLE)
                begin
                    st_d.phase = bpr_ph_conv;
                    st_d.timer = 16'(CONV_CYC);
                end
            end
            bpr_ph_conv:
            begin
                if (st_q.timer <= 16'h0001)
                begin
                    // Oversampling of zero skips that quantity and keeps the old value
                    if (st_q.cfg.meas.temp_os != `BPR_OS_SKIP)
                    begin
                        st_d.temp_res = align_result(temp_sample, st_q.cfg.meas.temp_os);
                    end
                    if (st_q.cfg.meas.baro_os != `BPR_OS_SKIP)
                    begin
                        st_d.baro_res = align_result(baro_sample, st_q.cfg.meas.baro_os);
                    end
                    if (st_q.cfg.meas.run_mode == `BPR_MODE_REPEAT)
                    begin
                        st_d.phase = bpr_ph_wait;
                        st_d.timer = stby_count(st_q.cfg.io.stby_sel);
                    end
                    else
                    begin
                        // Single shot falls back to idle on its own
                        st_d.phase = bpr_ph_idle;
                        st_d.cfg.meas.run_mode = `BPR_MODE_IDLE;
                    end
                end
                else
                begin
                    st_d.timer = st_q.timer - 16'h0001;
                end
            end
            bpr_ph_wait:
            begin
                if (st_q.cfg.meas.run_mode != `BPR_MODE_REPEAT)
                begin
                    st_d.phase = bpr_ph_idle;
                end
                else if (st_q.timer <= 16'h0001)
                begin
                    st_d.phase = bpr_ph_conv;
                    st_d.timer = 16'(CONV_CYC);
                end
                else
                begin
                    st_d.timer = st_q.timer - 16'h0001;
                end
            end
            default:
            begin
                st_d.phase = bpr_ph_idle;
            end
        endcase

        // Host write lands after the sequencer so a fresh mode is not lost
        if (wr_event)
        begin
            if (link_wr.addr == `BPR_ADDR_SOFT_RESET)
            begin
                if (link_wr.data == `BPR_SOFT_RESET_KEY)
                begin
                    st_d = TOP_RST;
                    st_d.wr_seen = tgl_sync[0];
                    st_d.rd_seen = tgl_sync[1];
                end
            end
            else if (link_wr.addr == `BPR_ADDR_IIR)
            begin
                st_d.cfg.iir_sel = link_wr.data[2:0];
            end
            else if (link_wr.addr == `BPR_ADDR_HS_CODE)
            begin
                st_d.cfg.hs_code = link_wr.data[2:0];
            end
            else if (link_wr.addr == `BPR_ADDR_MEAS_CTRL)
            begin
                st_d.cfg.meas = link_wr.data;
            end
            else if (link_wr.addr == `BPR_ADDR_IO_SETUP)
            begin
                st_d.cfg.io.stby_sel = link_wr.data[7:5];
                st_d.cfg.io.drive_type = link_wr.data[2];
                st_d.cfg.io.three_wire = link_wr.data[0];
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= TOP_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cfg_o = st_q.cfg;
    assign conv_busy = status_byte[`BPR_STATUS_MEAS_BIT];
    assign otp_busy = status_byte[`BPR_STATUS_OTP_BIT];

endmodule // bpr_top

`default_nettype wire

// ==== bpr_top_asserts.sv ====
/* Port assertions of the register bank, core clock domain.
   Assumes it is bound into bpr_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none

module bpr_top_asserts
    import bpr_pkg::*;
#(
    parameter int unsigned OTP_CYC = 4,
    parameter int unsigned CONV_CYC = 8,
    parameter int unsigned STBY_UNIT_CYC = 2
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic csb_n,
    input wire logic sdi_o,
    input wire logic sdi_oe,
    input wire logic sdo_oe,
    input wire bpr_cfg_s cfg_o,
    input wire logic conv_busy,
    input wire logic otp_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [15:0] run_q;

    // ----------------------------------------
    // Busy length, too long for a repetition
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            run_q <= 16'h0;
        else
            run_q <= conv_busy ? run_q + 16'h1 : 16'h0;
    end

    chk_reset_cfg: assert property ($rose(arst_n) |-> cfg_o == {5'h0, 8'h0, 3'h1, 3'h0})
        else $error("config not at reset value");
    chk_otp_load: assert property ($rose(arst_n) |-> otp_busy [*3] ##[1:4] !otp_busy)
        else $error("calibration load length wrong");
    chk_otp_excl: assert property (otp_busy |-> !conv_busy)
        else $error("measurement during calibration load");
    chk_conv_len: assert property ($fell(conv_busy) |-> run_q == CONV_CYC)
        else $error("measurement busy length wrong");
    chk_conv_cause: assert property ($rose(conv_busy) |-> $past(cfg_o.meas.run_mode) != 2'h0)
        else $error("measurement started while idle");
    chk_single_end: assert property (conv_busy && cfg_o.meas.run_mode inside {2'h1, 2'h2}
        ##1 !conv_busy |-> ##[0:2] cfg_o.meas.run_mode == 2'h0)
        else $error("single shot did not return to idle");
    chk_repeat_again: assert property ($fell(conv_busy) && cfg_o.meas.run_mode == 2'h3
        |-> ##[1:300] (conv_busy || cfg_o.meas.run_mode == 2'h0))
        else $error("repeating mode did not restart");
    chk_oe_idle: assert property (csb_n |-> !sdo_oe && !sdi_oe)
        else $error("pin driven outside a frame");
    chk_wire_mode: assert property (sdo_oe || sdi_oe
        |-> sdi_oe == cfg_o.io.three_wire && !(sdo_oe && sdi_oe))
        else $error("read data on wrong pin");
    chk_open_drain: assert property (sdi_oe && cfg_o.io.drive_type |-> !sdi_o)
        else $error("open drain pin driven high");

    cover property ($rose(conv_busy));
    cover property (sdi_oe && cfg_o.io.drive_type);
    cover property (sdo_oe);
endmodule // bpr_top_asserts

bind bpr_top bpr_top_asserts #(.OTP_CYC(OTP_CYC), .CONV_CYC(CONV_CYC),
    .STBY_UNIT_CYC(STBY_UNIT_CYC)) chk_u (.clock(clock), .arst_n(arst_n), .csb_n(csb_n),
    .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdo_oe(sdo_oe), .cfg_o(cfg_o),
    .conv_busy(conv_busy), .otp_busy(otp_busy));
`default_nettype wire

// ==== bpr_host.sv ====
/* Serial host model: mode 0 frames, sck stopped between frames.
   Assumes a pull-up on the shared data pin. */
`timescale 1ns/10ps
`default_nettype none

module bpr_host
(
    output var logic sck,
    output var logic csb_n,
    output logic sdi_i,
    input wire logic sdi_o,
    input wire logic sdi_oe,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic three_wire
);
    logic h_bit;
    logic h_oe;
    // Pull-up wins only when nobody drives
    assign sdi_i = sdi_oe ? sdi_o : (h_oe ? h_bit : 1'b1);
    initial
    begin
        sck = 1'b0;
        csb_n = 1'b1;
        h_bit = 1'b0;
        h_oe = 1'b0;
    end

    // Host arithmetic on coefficients and results; temperature in 1/256 degree
    function automatic real coef_k(input real a, input real s, input logic [7:0] hi,
        input logic [7:0] lo);
        return a + s * $itor($signed({hi, lo})) / 32767.0;
    endfunction
    function automatic int coef_off(input logic [7:0] b2, input logic [7:0] b1,
        input logic [7:0] b0);
        return int'($signed({b2, b1, b0}));
    endfunction
    function automatic real temp_c(input real aa, input real ba, input real ca,
        input real dt);
        return (-ba - $sqrt(ba * ba - 4.0 * aa * (ca - dt))) / (2.0 * aa);
    endfunction
    function automatic real abs_press(input real pl, input real at, input real bt,
        input real ct, input real tr);
        return pl / (at * tr * tr + bt * tr + ct + 1.0);
    endfunction
    function automatic int raw_code(input logic [23:0] v);
        return int'(v) - 8388608;
    endfunction

    task automatic byte8(input logic [7:0] b, input logic drv, output logic [7:0] got);
        h_oe = drv;
        for (int i = 7; i >= 0; i--)
        begin
            h_bit = b[i];
            #3;
            got[i] = three_wire ? sdi_i : (sdo_oe ? sdo_o : 1'bx);
            sck = 1'b1;
            #3;
            sck = 1'b0;
        end
        h_oe = 1'b0;
        // Pause lets the core see the byte before the next one
        #30;
    endtask

    task automatic xfer(input logic rd, input logic [7:0] a, input int n,
        input logic [23:0] wd, output logic [23:0] rv);
        logic [7:0] g;
        rv = 24'h0;
        csb_n = 1'b0;
        #10;
        byte8({rd, a[6:0]}, 1'b1, g);
        for (int k = n - 1; k >= 0; k--)
        begin
            byte8(wd[8*k +: 8], !rd, g);
            rv[8*k +: 8] = g;
        end
        csb_n = 1'b1;
        #10;
    endtask
endmodule // bpr_host
`default_nettype wire

// ==== pressure_sensor_register_map_tb.sv ====
/* Self-checking bench of the register bank with a serial host model.
   Assumes shortened load, conversion and standby counts. */
`timescale 1ns/10ps
`default_nettype none

module pressure_sensor_register_map_tb
    import bpr_pkg::*;
;
    localparam logic [7:0] PART = 8'h4b; // Arbitrary value
    logic clock, arst_n, tw, conv_busy, otp_busy, sdi_o, sdi_oe, sdo_o, sdo_oe;
    wire sck, csb_n, sdi_i;
    logic [23:0] temp_sample, baro_sample, rv, exp_t, exp_b;
    logic [7:0] d;
    logic [2:0] tos, bos;
    bpr_cfg_s cfg_o;
    int seed, err_count, total_checks, otp_rises;
    logic [7:0] addr_tab [14] = '{8'hd1, 8'he0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
        8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'h80};
    logic [7:0] rst_tab [14] = '{PART, 8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0,
        8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};

    bpr_top #(.PART_CODE(PART), .OTP_CYC(4), .CONV_CYC(8), .STBY_UNIT_CYC(2)) dut_u (
        .clock(clock), .arst_n(arst_n), .sck(sck), .csb_n(csb_n), .sdi_i(sdi_i),
        .sdi_o(sdi_o), .sdi_oe(sdi_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .temp_sample(temp_sample), .baro_sample(baro_sample), .cfg_o(cfg_o),
        .conv_busy(conv_busy), .otp_busy(otp_busy));
    bpr_host host_u (.sck(sck), .csb_n(csb_n), .sdi_i(sdi_i), .sdi_o(sdi_o),
        .sdi_oe(sdi_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .three_wire(tw));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge otp_busy) otp_rises++;

    task chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        host_u.xfer(1'b0, a, 1, {16'h0, v}, rv);
    endtask
    task rd_chk(input logic [7:0] a, input int n, input logic [23:0] e);
        host_u.xfer(1'b1, a, n, 24'h0, rv);
        chk(rv, e);
    endtask
    // Bounded wait for one busy pulse to start and end
    task wait_conv;
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 300 && !(seen && conv_busy === 1'b0); i++)
        begin
            @(negedge clock);
            seen = seen || conv_busy === 1'b1;
        end
        chk(seen, 1'b1);
    endtask
    function automatic logic [23:0] align(input logic [2:0] os, input logic [23:0] s,
        input logic [23:0] old);
        case (os)
            3'h0: return old;
            3'h1: return {s[21:0], 2'h0};
            3'h2: return {s[22:0], 1'h0};
            default: return s;
        endcase
    endfunction
    task give_verdict;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_count++;
        give_verdict;
    end

    initial
    begin
        seed = 97;
        {arst_n, tw, temp_sample, baro_sample, exp_t, exp_b} = '0;
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        repeat (10) @(negedge clock);
        for (int i = 0; i < 14; i++) rd_chk(addr_tab[i], 1, rst_tab[i]);
        for (int i = 0; i < 8; i++)
        begin
            d = $random(seed);
            wr(8'hf1, d);
            wr(8'hf2, d);
            wr(8'hf4, d & 8'hfc);
            wr(8'hf5, d & 8'hfe);
            rd_chk(8'hf1, 1, d & 8'h07);
            rd_chk(8'hf2, 1, d & 8'h07);
            rd_chk(8'hf4, 1, d & 8'hfc);
            rd_chk(8'hf5, 1, d & 8'he4);
            chk(cfg_o, {d[7:5], d[2], 1'b0, d[7:2], 2'h0, d[2:0], d[2:0]});
        end
        wr(8'hd1, ~PART);
        wr(8'hfa, 8'h55);
        rd_chk(8'hd1, 1, PART);
        rd_chk(8'hfa, 1, 24'h0);
        wr(8'hf5, 8'h00);
        // Host order: start, then temperature, then pressure
        for (int i = 0; i < 8; i++)
        begin
            tos = i[2:0];
            bos = 3'h7 - i[2:0];
            @(negedge clock);
            temp_sample = $random(seed);
            baro_sample = $random(seed);
            exp_t = align(tos, temp_sample, exp_t);
            exp_b = align(bos, baro_sample, exp_b);
            wr(8'hf4, {tos, bos, i[0] ? 2'h2 : 2'h1});
            wait_conv;
            rd_chk(8'hfa, 3, exp_t);
            rd_chk(8'hf7, 3, exp_b);
            rd_chk(8'hf4, 1, {tos, bos, 2'h0});
        end
        wr(8'hf5, 8'h20);
        wr(8'hf4, 8'hff);
        wait_conv;
        wait_conv;
        wr(8'hf4, 8'h00);
        repeat (60) @(negedge clock);
        chk(conv_busy, 1'b0);
        wr(8'hf5, 8'h05);
        tw = 1'b1;
        rd_chk(8'hd1, 1, PART);
        wr(8'hf5, 8'h01);
        rd_chk(8'hfa, 3, exp_t);
        chk(host_u.raw_code(rv), exp_t ^ 24'h800000);
        wr(8'hf5, 8'h00);
        tw = 1'b0;
        wr(8'hf1, 8'h05);
        wr(8'he0, 8'h55);
        rd_chk(8'hf1, 1, 24'h5);
        d = otp_rises;
        wr(8'he0, 8'he6);
        repeat (10) @(negedge clock);
        chk(otp_rises, d + 1);
        rd_chk(8'hf1, 1, 24'h0);
        rd_chk(8'hf2, 1, 24'h1);
        wr(8'hf2, 8'h06);
        rd_chk(8'hf2, 1, 24'h6);
        @(negedge clock);
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        chk(cfg_o, {5'h0, 8'h0, 3'h1, 3'h0});
        arst_n = 1'b1;
        repeat (10) @(negedge clock);
        rd_chk(8'hf2, 1, 24'h1);
        chk($rtoi(host_u.coef_k(30.0, 10.0, 8'h7f, 8'hff)), 24'd40);
        chk(host_u.coef_off(8'h12, 8'h34, 8'h56), 24'h123456);
        chk($rtoi(host_u.temp_c(-1.0, 0.0, 0.0, -40960000.0)), 24'd6400);
        chk($rtoi(host_u.abs_press(100000.0, 0.0, 0.0, 1.0, 6400.0)), 24'd50000);
        give_verdict;
    end
endmodule // pressure_sensor_register_map_tb
`default_nettype wire
